//--- src/pid_setpoint_controller.sv
// Sampled setpoint regulator: target select, deviation, P/I/D, lag, bias
// Behaviour
// - Lowest source digit picks analog or preset one
// - Step inputs pick presets; jog picks fifth
// - Feedback from voltage or current channel
// - Deviation is target minus gained feedback
// - Proportional term is deviation times gain
// - Integral adds deviation times 7 ms/Ti
// - Derivative is deviation change times Td/7 ms
// - Output sums P, I and D terms; D is left out while integral time is zero
// - Regulator runs only with enable code 09
// - Derivative time zero gives zero derivative
// - First-order lag filter on regulator path
// - Bias 0 to 109 percent added
// - Feedback gain 0.01 to 10.00, default 1.00
`timescale 1ns/1ns
module pid_setpoint_controller #(
  parameter int SAMPLE_CYCLES = pid_pkg::SAMPLE_CYCLES
) (
  input  wire logic                    clk_sys,
  input  wire logic                    rst_b,
  input  wire logic                    ce,
  input  wire logic [pid_pkg::AW-1:0]  addr,
  input  wire logic [pid_pkg::DW-1:0]  wdata,
  input  wire logic                    wr_stb,
  input  wire logic                    rd_stb,
  output logic      [pid_pkg::DW-1:0]  rdata,
  input  wire logic                    multi_step1,
  input  wire logic                    multi_step2,
  input  wire logic                    jog_cmd,
  input  wire logic [3:0]              contact_hi,
  input  wire logic [pid_pkg::DW-1:0]  analog_ref,
  input  wire logic [pid_pkg::DW-1:0]  fb_voltage,
  input  wire logic [pid_pkg::DW-1:0]  fb_current,
  output logic      [pid_pkg::DW-1:0]  ctrl_out_r,
  output logic                         ctrl_valid_r,
  output logic                         active_r,
  output logic                         conflict_r
);
  localparam int W = pid_pkg::W;

  typedef enum logic [2:0] {ST_IDLE, ST_FB, ST_P, ST_I, ST_D, ST_SUM, ST_LAG, ST_OUT} st_t;

  pid_cfg_if cfg ();

  st_t                 st_r;
  logic [31:0]         tick_cnt_r;
  logic                tick;
  logic [W-1:0]        target_r;
  logic [W-1:0]        fb_r;
  logic [W-1:0]        dev_r;
  logic [W-1:0]        prev_dev_r;
  logic [W-1:0]        p_term_r;
  logic [W-1:0]        i_acc_r;
  logic [W-1:0]        d_term_r;
  logic [W-1:0]        sum_r;
  logic [W-1:0]        lag_acc_r;
  logic                div_start_r;
  logic [W-1:0]        div_num_r;
  logic [W-1:0]        div_den_r;
  logic                div_done;
  logic [W-1:0]        div_q;
  logic [W-1:0]        out_full;
  logic [W-1:0]        d_now;
  logic                enabled;

  pid_regs u_regs (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .ce      (ce),
    .addr    (addr),
    .wdata   (wdata),
    .wr_stb  (wr_stb),
    .rd_stb  (rd_stb),
    .rdata_r (rdata),
    .cfg     (cfg.regs)
  );

  pid_divider #(.W(W)) u_div (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .ce      (ce),
    .start   (div_start_r),
    .num     (div_num_r),
    .den     (div_den_r),
    .done_r  (div_done),
    .quot_r  (div_q)
  );

  assign enabled = (cfg.enable_sel == pid_pkg::ENABLE_CODE);
  assign tick    = ce && (tick_cnt_r == SAMPLE_CYCLES - 1);

  // Derivative quotient lands in the sum step; it must join this sample's sum
  assign d_now = (st_r == ST_SUM && div_done && cfg.i_time != '0 && cfg.d_time != '0) ?
                 div_q : '0;

  // Status back to the register file
  assign cfg.active   = active_r;
  assign cfg.conflict = conflict_r;
  assign cfg.out_val  = ctrl_out_r;
  assign cfg.dev_val  = dev_r[pid_pkg::DW-1:0];

  // Free-running 7 ms sample timer
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tick_cnt_r <= '0;
    end else if (ce) begin
      tick_cnt_r <= tick ? '0 : tick_cnt_r + 1'b1;
    end
  end

  // Enable and contact conflict flags
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      active_r   <= 1'b0;
      conflict_r <= 1'b0;
    end else if (ce) begin
      active_r   <= enabled;
      conflict_r <= (|contact_hi) && (cfg.fn_code[0] == pid_pkg::HOLD_OPEN_CODE ||
                    cfg.fn_code[1] == pid_pkg::HOLD_OPEN_CODE ||
                    cfg.fn_code[2] == pid_pkg::HOLD_OPEN_CODE ||
                    cfg.fn_code[3] == pid_pkg::HOLD_OPEN_CODE);
    end
  end

  // Target and feedback capture at each sample
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      target_r <= '0;
      fb_r     <= '0;
    end else if (tick) begin
      if (jog_cmd) begin
        target_r <= W'(cfg.preset[4]);
      end else begin
        unique case ({multi_step2, multi_step1})
          2'b00: target_r <= (cfg.ref_src[0] == 1'b0) ? W'(analog_ref)
                                                       : W'(cfg.preset[0]);
          2'b01: target_r <= W'(cfg.preset[1]);
          2'b10: target_r <= W'(cfg.preset[2]);
          2'b11: target_r <= W'(cfg.preset[3]);
        endcase
      end
      fb_r <= cfg.fb_src ? W'(fb_current) : W'(fb_voltage);
    end
  end

  // Sequencer: each step from ST_FB to ST_SUM hands at most one division to the shared divider
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_r        <= ST_IDLE;
      div_start_r <= 1'b0;
      div_num_r   <= '0;
      div_den_r   <= '0;
    end else if (ce) begin
      div_start_r <= 1'b0;
      unique case (st_r)
        ST_IDLE: begin
          if (tick && enabled) begin
            st_r <= ST_FB;
          end
        end
        ST_FB: begin
          div_num_r   <= W'(fb_r * cfg.fb_gain);
          div_den_r   <= W'(pid_pkg::FB_GAIN_DIV);
          div_start_r <= 1'b1;
          st_r        <= ST_P;
        end
        ST_P: begin
          if (div_done) begin
            div_num_r   <= W'((target_r - div_q) * $signed({1'b0, cfg.p_gain}));
            div_den_r   <= W'(pid_pkg::P_GAIN_DIV);
            div_start_r <= 1'b1;
            st_r        <= ST_I;
          end
        end
        ST_I: begin
          if (div_done) begin
            div_num_r   <= W'((dev_r * pid_pkg::SAMPLE_MS) <<< pid_pkg::FRAC);
            div_den_r   <= W'(cfg.i_time * pid_pkg::MS_PER_TENTH);
            div_start_r <= (cfg.i_time != '0);
            st_r        <= (cfg.i_time != '0) ? ST_D : ST_SUM;
          end
        end
        ST_D: begin
          if (div_done) begin
            div_num_r   <= W'((dev_r - prev_dev_r) * $signed({1'b0, cfg.d_time})
                              * pid_pkg::MS_PER_HUND);
            div_den_r   <= W'(pid_pkg::SAMPLE_MS);
            div_start_r <= 1'b1;
            st_r        <= ST_SUM;
          end
        end
        ST_SUM: begin
          if (div_done || cfg.i_time == '0) begin
            div_num_r   <= W'(((p_term_r + (i_acc_r >>> pid_pkg::FRAC) + d_now)
                              <<< pid_pkg::FRAC) - lag_acc_r) * pid_pkg::SAMPLE_MS;
            div_den_r   <= W'(cfg.lag_tc * pid_pkg::MS_PER_TENTH);
            div_start_r <= (cfg.lag_tc != '0);
            st_r        <= (cfg.lag_tc != '0) ? ST_LAG : ST_OUT;
          end
        end
        ST_LAG: begin
          if (div_done) begin
            st_r <= ST_OUT;
          end
        end
        ST_OUT: st_r <= ST_IDLE;
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // Regulator terms; integral and previous deviation cleared while off
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      dev_r      <= '0;
      prev_dev_r <= '0;
      p_term_r   <= '0;
      i_acc_r    <= '0;
      d_term_r   <= '0;
      sum_r      <= '0;
    end else if (ce) begin
      if (!enabled) begin
        prev_dev_r <= '0;
        i_acc_r    <= '0;
      end else begin
        unique case (st_r)
          ST_P: if (div_done) dev_r <= target_r - div_q;
          ST_I: begin
            if (div_done) p_term_r <= div_q;
            if (div_done && cfg.i_time == '0) d_term_r <= '0;
          end
          ST_D: begin
            if (div_done) i_acc_r <= i_acc_r + div_q;
          end
          ST_SUM: begin
            d_term_r <= d_now;
            sum_r    <= p_term_r + (i_acc_r >>> pid_pkg::FRAC) + d_now;
          end
          ST_OUT: prev_dev_r <= dev_r;
          default: ;
        endcase
        if (st_r == ST_SUM && cfg.d_time == '0) begin
          d_term_r <= '0;
        end
      end
    end
  end

  // Lag accumulator steps toward the sum; zero time constant loads the sum directly
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      lag_acc_r <= '0;
    end else if (ce) begin
      if (!enabled) begin
        lag_acc_r <= '0;
      end else if (st_r == ST_LAG && div_done) begin
        lag_acc_r <= lag_acc_r + div_q;
      end else if (st_r == ST_SUM && cfg.lag_tc == '0 && (div_done || cfg.i_time == '0)) begin
        lag_acc_r <= (p_term_r + (i_acc_r >>> pid_pkg::FRAC) + d_now) <<< pid_pkg::FRAC;
      end
    end
  end

  assign out_full = (lag_acc_r >>> pid_pkg::FRAC) + W'(cfg.bias * pid_pkg::BIAS_SCALE);

  // Saturated output with bias, zero while the regulator is off
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_out_r   <= '0;
      ctrl_valid_r <= 1'b0;
    end else if (ce) begin
      ctrl_valid_r <= 1'b0;
      if (!enabled) begin
        ctrl_out_r <= '0;
      end else if (st_r == ST_OUT) begin
        ctrl_valid_r <= 1'b1;
        ctrl_out_r   <= out_full[W-1] ? '0 :
                        (out_full > W'(pid_pkg::OUT_MAX)) ? 16'hffff : out_full[15:0];
      end
    end
  end

  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  sequence s_sample;
    tick && enabled && st_r == ST_IDLE;
  endsequence
  sequence s_start_fb;
    st_r == ST_FB;
  endsequence

  chk_jog_preset: assert property (tick && jog_cmd |=> target_r == W'(cfg.preset[4]))
    else $error("jog target not fifth preset");
  chk_analog_ref: assert property (tick && !jog_cmd && !multi_step1 && !multi_step2
    && cfg.ref_src[0] == 1'b0 |=> target_r == W'($past(analog_ref)))
    else $error("analog target not used");
  chk_fb_select: assert property (tick |=> fb_r == ($past(cfg.fb_src) ?
    W'($past(fb_current)) : W'($past(fb_voltage))))
    else $error("feedback channel wrong");
  chk_sample_start: assert property (s_sample |=> s_start_fb)
    else $error("sample did not start sequence");
  chk_d_zero: assert property (ce && st_r == ST_OUT && cfg.d_time == '0 |-> d_term_r == '0)
    else $error("derivative not zero");
  chk_sum_terms: assert property (ce && enabled && st_r == ST_SUM |=>
    sum_r == $past(p_term_r) + ($past(i_acc_r) >>> pid_pkg::FRAC) + $past(d_now))
    else $error("sum mismatch");
  chk_disabled_out: assert property (ce && !enabled |=> ctrl_out_r == '0 && i_acc_r == '0)
    else $error("output while disabled");
  chk_prev_dev: assert property (ce && enabled && st_r == ST_OUT |=> prev_dev_r == $past(dev_r))
    else $error("previous deviation not stored");
endmodule

//--- src/pid_pkg.sv
// Shared constants for the sampled setpoint regulator
package pid_pkg;
  // Widths
  localparam int DW   = 16;             // Register and sample width
  localparam int AW   = 5;              // Register word address width
  localparam int W    = 40;             // Internal arithmetic width
  localparam int FRAC = 8;              // Fraction bits of accumulators

  // Register word addresses
  localparam logic [AW-1:0] ADDR_PRESET_ONE   = 5'h00;
  localparam logic [AW-1:0] ADDR_PRESET_TWO   = 5'h01;
  localparam logic [AW-1:0] ADDR_PRESET_THREE = 5'h02;
  localparam logic [AW-1:0] ADDR_PRESET_FOUR  = 5'h03;
  localparam logic [AW-1:0] ADDR_PRESET_JOG   = 5'h04;
  localparam logic [AW-1:0] ADDR_FB_GAIN      = 5'h05;
  localparam logic [AW-1:0] ADDR_P_GAIN       = 5'h06;
  localparam logic [AW-1:0] ADDR_I_TIME       = 5'h07;
  localparam logic [AW-1:0] ADDR_D_TIME       = 5'h08;
  localparam logic [AW-1:0] ADDR_BIAS         = 5'h09;
  localparam logic [AW-1:0] ADDR_LAG_TC       = 5'h0a;
  localparam logic [AW-1:0] ADDR_REF_SRC      = 5'h0b;
  localparam logic [AW-1:0] ADDR_ENABLE_SEL   = 5'h0c;
  localparam logic [AW-1:0] ADDR_FN_CODES_LO  = 5'h0d;
  localparam logic [AW-1:0] ADDR_FN_CODES_HI  = 5'h0e;
  localparam logic [AW-1:0] ADDR_FB_SRC       = 5'h0f;
  localparam logic [AW-1:0] ADDR_STATUS       = 5'h10;
  localparam logic [AW-1:0] ADDR_OUTPUT       = 5'h11;
  localparam logic [AW-1:0] ADDR_DEVIATION    = 5'h12;

  // Reset values (units: 0.01 Hz, 0.01, 0.1, 0.1 s, 0.01 s, 1 %, 0.1 s)
  localparam logic [DW-1:0] RST_PRESET_ONE = 16'h1770;  // 60.00
  localparam logic [DW-1:0] RST_PRESET     = 16'h0000;
  localparam logic [DW-1:0] RST_PRESET_JOG = 16'h0258;  // 6.00
  localparam logic [DW-1:0] RST_FB_GAIN    = 16'h0064;  // 1.00
  localparam logic [DW-1:0] RST_P_GAIN     = 16'h000a;  // 1.0
  localparam logic [DW-1:0] RST_I_TIME     = 16'h0064;  // 10.0 s
  localparam logic [DW-1:0] RST_D_TIME     = 16'h0000;
  localparam logic [DW-1:0] RST_BIAS       = 16'h0000;
  localparam logic [DW-1:0] RST_LAG_TC     = 16'h0000;

  // Setting ranges
  localparam logic [DW-1:0] FB_GAIN_MIN = 16'h0001;     // 0.01
  localparam logic [DW-1:0] FB_GAIN_MAX = 16'h03e8;     // 10.00
  localparam logic [DW-1:0] BIAS_MAX    = 16'h006d;     // 109 %

  // Selection codes
  localparam logic [7:0] ENABLE_CODE    = 8'h09;
  localparam logic [7:0] HOLD_OPEN_CODE = 8'h66;
  localparam int         STAT_ACTIVE    = 0;
  localparam int         STAT_CONFLICT  = 1;

  // Sample timing
  localparam int SAMPLE_NS     = 7000000;                // 7 ms
  localparam int CLK_PERIOD_NS = 4;
  localparam int SAMPLE_CYCLES = SAMPLE_NS / CLK_PERIOD_NS;
  localparam int SAMPLE_MS     = 7;

  // Scale factors
  localparam int FB_GAIN_DIV  = 100;     // Gain in 0.01 steps
  localparam int P_GAIN_DIV   = 10;      // Gain in 0.1 steps
  localparam int MS_PER_TENTH = 100;     // 0.1 s in ms
  localparam int MS_PER_HUND  = 10;      // 0.01 s in ms
  localparam int BIAS_SCALE   = 400;     // Counts per percent, 100 % = 400.00
  localparam int OUT_MAX      = 65535;
endpackage

//--- src/pid_cfg_if.sv
// Settings and status carried between register file and regulator core
`timescale 1ns/1ns
interface pid_cfg_if;
  logic [pid_pkg::DW-1:0] preset [0:4];
  logic [pid_pkg::DW-1:0] fb_gain;
  logic [pid_pkg::DW-1:0] p_gain;
  logic [pid_pkg::DW-1:0] i_time;
  logic [pid_pkg::DW-1:0] d_time;
  logic [pid_pkg::DW-1:0] bias;
  logic [pid_pkg::DW-1:0] lag_tc;
  logic [3:0]             ref_src;
  logic [7:0]             enable_sel;
  logic [7:0]             fn_code [0:3];
  logic                   fb_src;
  logic                   active;
  logic                   conflict;
  logic [pid_pkg::DW-1:0] out_val;
  logic [pid_pkg::DW-1:0] dev_val;

  modport regs (output preset, fb_gain, p_gain, i_time, d_time, bias, lag_tc, ref_src,
                enable_sel, fn_code, fb_src, input active, conflict, out_val, dev_val);
  modport core (input preset, fb_gain, p_gain, i_time, d_time, bias, lag_tc, ref_src,
                enable_sel, fn_code, fb_src, output active, conflict, out_val, dev_val);
endinterface

//--- src/pid_divider.sv
// Serial signed-by-unsigned divider, one quotient bit per cycle
`timescale 1ns/1ns
module pid_divider #(
  parameter int W = pid_pkg::W
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_b,
  input  wire logic         ce,
  input  wire logic         start,
  input  wire logic [W-1:0] num,
  input  wire logic [W-1:0] den,
  output logic              done_r,
  output logic [W-1:0]      quot_r
);
  logic [W-1:0]         rem_r;
  logic [W-1:0]         q_r;
  logic [W-1:0]         den_r;
  logic                 neg_r;
  logic                 busy_r;
  logic [$clog2(W):0]   cnt_r;
  logic [W:0]           shifted;
  logic [W:0]           trial;

  // Shift in the next dividend bit and try the subtraction
  assign shifted = {rem_r, q_r[W-1]};
  assign trial   = shifted - {1'b0, den_r};

  // Iteration, truncating toward zero
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rem_r  <= '0;
      q_r    <= '0;
      den_r  <= '0;
      neg_r  <= 1'b0;
      busy_r <= 1'b0;
      cnt_r  <= '0;
      done_r <= 1'b0;
      quot_r <= '0;
    end else if (ce) begin
      done_r <= 1'b0;
      if (start) begin
        rem_r  <= '0;
        q_r    <= num[W-1] ? W'(-num) : num;
        neg_r  <= num[W-1];
        den_r  <= den;
        busy_r <= 1'b1;
        cnt_r  <= ($clog2(W)+1)'(W);
      end else if (busy_r) begin
        if (!trial[W]) begin
          rem_r <= trial[W-1:0];
          q_r   <= {q_r[W-2:0], 1'b1};
        end else begin
          rem_r <= shifted[W-1:0];
          q_r   <= {q_r[W-2:0], 1'b0};
        end
        cnt_r <= cnt_r - 1'b1;
        if (cnt_r == 1) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
          quot_r <= neg_r ? W'(-{q_r[W-2:0], !trial[W]}) : {q_r[W-2:0], !trial[W]};
        end
      end
    end
  end
endmodule

//--- src/pid_regs.sv
// Register file: settings written by software, status read back
`timescale 1ns/1ns
module pid_regs (
  input  wire logic                    clk_sys,
  input  wire logic                    rst_b,
  input  wire logic                    ce,
  input  wire logic [pid_pkg::AW-1:0]  addr,
  input  wire logic [pid_pkg::DW-1:0]  wdata,
  input  wire logic                    wr_stb,
  input  wire logic                    rd_stb,
  output logic      [pid_pkg::DW-1:0]  rdata_r,
  pid_cfg_if.regs                      cfg
);
  logic [pid_pkg::DW-1:0] preset_r [0:4];

  // Preset storage, one word per target
  generate
    for (genvar i = 0; i < 5; i++) begin : g_preset
      always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          preset_r[i] <= (i == 0) ? pid_pkg::RST_PRESET_ONE :
                         (i == 4) ? pid_pkg::RST_PRESET_JOG : pid_pkg::RST_PRESET;
        end else if (ce && wr_stb && addr == pid_pkg::AW'(i)) begin
          preset_r[i] <= wdata;
        end
      end
      assign cfg.preset[i] = preset_r[i];
    end
  endgenerate

  // Tuning settings; out-of-range writes are clamped to the limits
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cfg.fb_gain    <= pid_pkg::RST_FB_GAIN;
      cfg.p_gain     <= pid_pkg::RST_P_GAIN;
      cfg.i_time     <= pid_pkg::RST_I_TIME;
      cfg.d_time     <= pid_pkg::RST_D_TIME;
      cfg.bias       <= pid_pkg::RST_BIAS;
      cfg.lag_tc     <= pid_pkg::RST_LAG_TC;
      cfg.ref_src    <= '0;
      cfg.enable_sel <= '0;
      cfg.fn_code    <= '{default: '0};
      cfg.fb_src     <= 1'b0;
    end else if (ce && wr_stb) begin
      unique case (addr)
        pid_pkg::ADDR_FB_GAIN: begin
          cfg.fb_gain <= (wdata < pid_pkg::FB_GAIN_MIN) ? pid_pkg::FB_GAIN_MIN :
                         (wdata > pid_pkg::FB_GAIN_MAX) ? pid_pkg::FB_GAIN_MAX : wdata;
        end
        pid_pkg::ADDR_P_GAIN:     cfg.p_gain  <= wdata;
        pid_pkg::ADDR_I_TIME:     cfg.i_time  <= wdata;
        pid_pkg::ADDR_D_TIME:     cfg.d_time  <= wdata;
        pid_pkg::ADDR_BIAS: begin
          cfg.bias <= (wdata > pid_pkg::BIAS_MAX) ? pid_pkg::BIAS_MAX : wdata;
        end
        pid_pkg::ADDR_LAG_TC:     cfg.lag_tc     <= wdata;
        pid_pkg::ADDR_REF_SRC:    cfg.ref_src    <= wdata[3:0];
        pid_pkg::ADDR_ENABLE_SEL: cfg.enable_sel <= wdata[7:0];
        pid_pkg::ADDR_FN_CODES_LO: begin
          cfg.fn_code[0] <= wdata[7:0];
          cfg.fn_code[1] <= wdata[15:8];
        end
        pid_pkg::ADDR_FN_CODES_HI: begin
          cfg.fn_code[2] <= wdata[7:0];
          cfg.fn_code[3] <= wdata[15:8];
        end
        pid_pkg::ADDR_FB_SRC:     cfg.fb_src <= wdata[0];
        default: ;
      endcase
    end
  end

  // Read data one cycle after the strobe; unmapped words read zero
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= '0;
    end else if (ce) begin
      rdata_r <= '0;
      if (rd_stb) begin
        if (addr <= pid_pkg::ADDR_PRESET_JOG) rdata_r <= preset_r[addr[2:0]];
        unique case (addr)
          pid_pkg::ADDR_FB_GAIN:     rdata_r <= cfg.fb_gain;
          pid_pkg::ADDR_P_GAIN:      rdata_r <= cfg.p_gain;
          pid_pkg::ADDR_I_TIME:      rdata_r <= cfg.i_time;
          pid_pkg::ADDR_D_TIME:      rdata_r <= cfg.d_time;
          pid_pkg::ADDR_BIAS:        rdata_r <= cfg.bias;
          pid_pkg::ADDR_LAG_TC:      rdata_r <= cfg.lag_tc;
          pid_pkg::ADDR_REF_SRC:     rdata_r <= {12'h000, cfg.ref_src};
          pid_pkg::ADDR_ENABLE_SEL:  rdata_r <= {8'h00, cfg.enable_sel};
          pid_pkg::ADDR_FN_CODES_LO: rdata_r <= {cfg.fn_code[1], cfg.fn_code[0]};
          pid_pkg::ADDR_FN_CODES_HI: rdata_r <= {cfg.fn_code[3], cfg.fn_code[2]};
          pid_pkg::ADDR_FB_SRC:      rdata_r <= {15'h0000, cfg.fb_src};
          pid_pkg::ADDR_STATUS:      rdata_r <= {14'h0000, cfg.conflict, cfg.active};
          pid_pkg::ADDR_OUTPUT:      rdata_r <= cfg.out_val;
          pid_pkg::ADDR_DEVIATION:   rdata_r <= cfg.dev_val;
          default: ;
        endcase
      end
    end
  end

  // Setting limits hold at all times
  chk_bias_limit: assert property (@(posedge clk_sys) disable iff (!rst_b)
    cfg.bias <= pid_pkg::BIAS_MAX) else $error("bias above limit");
  chk_gain_limit: assert property (@(posedge clk_sys) disable iff (!rst_b)
    cfg.fb_gain >= pid_pkg::FB_GAIN_MIN && cfg.fb_gain <= pid_pkg::FB_GAIN_MAX)
    else $error("feedback gain out of range");
endmodule

//--- dv/pid_contact_model.sv
// Far-side model: contact inputs and feedback sensor
`timescale 1ns/1ns
module pid_contact_model (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic [2:0]  want_sel,
  input  wire logic [3:0]  want_hi,
  input  wire logic [47:0] want_ana,
  input  wire logic        hold_open,
  output logic             multi_step1,
  output logic             multi_step2,
  output logic             jog_cmd,
  output logic      [3:0]  contact_hi,
  output logic      [47:0] ana
);
  // Contacts and sensor levels change just after an edge
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      {jog_cmd, multi_step2, multi_step1} <= 3'h0;
      contact_hi <= 4'h0;
      ana <= 48'h0;
    end else begin
      {jog_cmd, multi_step2, multi_step1} <= want_sel;
      contact_hi <= hold_open ? 4'h0 : want_hi;
      ana <= want_ana;
    end
  end
endmodule

//--- dv/pid_setpoint_controller_tb_top.sv
// Self-checking bench for the sampled setpoint regulator
`timescale 1ns/1ns
module pid_setpoint_controller_tb_top;
  logic                   clk_sys, rst_b, wr_stb, rd_stb, ms1, ms2, jog;
  logic                   valid, act, cfl;
  logic [pid_pkg::AW-1:0] addr;
  logic [pid_pkg::DW-1:0] wdata, rdata, out;
  logic [2:0]             sel;
  logic [3:0]             hi;
  logic [47:0]            want, ana;
  int                     err_count, comparisons, cyc;

  pid_contact_model u_far (.clk_sys(clk_sys), .rst_b(rst_b), .want_sel(sel), .want_hi(4'hf),
    .want_ana(want), .hold_open(1'b1), .multi_step1(ms1), .multi_step2(ms2), .jog_cmd(jog),
    .contact_hi(hi), .ana(ana));
  pid_setpoint_controller #(.SAMPLE_CYCLES(300)) u_dut (.clk_sys(clk_sys), .rst_b(rst_b),
    .ce(1'b1), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .multi_step1(ms1), .multi_step2(ms2), .jog_cmd(jog), .contact_hi(hi),
    .analog_ref(ana[47:32]), .fb_voltage(ana[31:16]), .fb_current(ana[15:0]),
    .ctrl_out_r(out), .ctrl_valid_r(valid), .active_r(act), .conflict_r(cfl));

  task automatic end_sim;
    if (err_count == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(string n, logic [15:0] got, logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s exp %h got %h", n, exp, got);
    end
  endtask
  task automatic wr(logic [4:0] a, logic [15:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk_sys);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(logic [4:0] a, logic [15:0] exp);
    @(posedge clk_sys);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk_sys);
    rd_stb <= 1'b0;
    #1 chk("rdata", rdata, exp);
  endtask
  // Skip the sample in flight, then check the next output
  task automatic outchk(logic [15:0] exp);
    repeat (2) @(posedge clk_sys iff valid === 1'b1);
    #1 chk("ctrl_out", out, exp);
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // Hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      end_sim();
    end
  end

  initial begin
    {rst_b, wr_stb, rd_stb, addr, wdata, sel, want} = '0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    rd(pid_pkg::ADDR_FB_GAIN, 16'h0064);
    rd(pid_pkg::ADDR_D_TIME, 16'h0000);
    rd(pid_pkg::ADDR_BIAS, 16'h0000);
    wr(pid_pkg::ADDR_FB_GAIN, 16'h0000);
    rd(pid_pkg::ADDR_FB_GAIN, 16'h0001);
    wr(pid_pkg::ADDR_FB_GAIN, 16'h07d0);
    rd(pid_pkg::ADDR_FB_GAIN, 16'h03e8);
    wr(pid_pkg::ADDR_BIAS, 16'h00c8);
    rd(pid_pkg::ADDR_BIAS, 16'h006d);
    rd(5'h1f, 16'h0000);
    wr(pid_pkg::ADDR_FB_GAIN, 16'h0064);
    wr(pid_pkg::ADDR_BIAS, 16'h0000);
    wr(pid_pkg::ADDR_I_TIME, 16'h0000);
    wr(pid_pkg::ADDR_REF_SRC, 16'h0001);
    wr(pid_pkg::ADDR_ENABLE_SEL, 16'h0009);
    // Each step code and jog picks its own preset
    for (int k = 0; k < 5; k++) begin
      wr(5'(k), 16'(1000 * (k + 1)));
      sel <= (k == 4) ? 3'h4 : 3'(k);
      outchk(16'(1000 * (k + 1)));
    end
    chk("active", 16'(act), 16'h0001);
    wr(pid_pkg::ADDR_FN_CODES_LO, 16'h0066);
    repeat (2) @(posedge clk_sys);
    #1 chk("conflict", 16'(cfl), 16'h0000);
    rd(pid_pkg::ADDR_STATUS, 16'h0001);
    sel <= 3'h0;
    wr(pid_pkg::ADDR_REF_SRC, 16'h0000);
    want <= {16'd777, 16'd300, 16'd100};
    outchk(16'd477);
    wr(pid_pkg::ADDR_FB_GAIN, 16'h00c8);
    outchk(16'd177);
    wr(pid_pkg::ADDR_FB_SRC, 16'h0001);
    outchk(16'd577);
    rd(pid_pkg::ADDR_DEVIATION, 16'd577);
    wr(pid_pkg::ADDR_P_GAIN, 16'h0014);
    outchk(16'd1154);
    wr(pid_pkg::ADDR_D_TIME, 16'h0007);
    outchk(16'd1154);
    wr(pid_pkg::ADDR_BIAS, 16'h0001);
    outchk(16'd1554);
    wr(pid_pkg::ADDR_ENABLE_SEL, 16'h0008);
    repeat (3) @(posedge clk_sys);
    #1 chk("active", 16'(act), 16'h0000);
    chk("ctrl_out", out, 16'h0000);
    end_sim();
  end
endmodule
